// [core/mgmt_pkg.sv]
package mgmt_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] OFF_CONTROL  = 8'h00;
	localparam logic [7:0] OFF_RAW      = 8'h04;
	localparam logic [7:0] OFF_MASKED   = 8'h08;
	localparam logic [7:0] OFF_EN_SET   = 8'h0c;
	localparam logic [7:0] OFF_EN_CLR   = 8'h10;
	localparam logic [7:0] OFF_MANUAL   = 8'h14;
	localparam logic [7:0] OFF_MODE_GAP = 8'h18;
	localparam logic [7:0] OFF_POLL_EN  = 8'h1c;
	localparam logic [7:0] OFF_FORMAT   = 8'h20;
	localparam logic [7:0] OFF_EXT0     = 8'h24;
	localparam logic [7:0] OFF_EXT1     = 8'h28;
	localparam logic [7:0] OFF_ACCESS0  = 8'h2c;
	localparam logic [7:0] OFF_ACCESS1  = 8'h30;
	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int          CTRL_TEST_BIT  = 17;
	localparam int          CTRL_POLL_BIT  = 30;
	localparam int          MAN_CLK_BIT    = 2;
	localparam int          MAN_OE_BIT     = 1;
	localparam int          MAN_PIN_BIT    = 0;
	localparam int          SWPIN_BIT      = 31;
	localparam int          ANYCHG_BIT     = 30;
	localparam logic [15:0] DIV_RESET      = 16'h00ff;
	localparam logic [31:0] POLL_MASK_RST  = 32'hffffffff;
	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam logic [6:0]  FRAME_BITS     = 7'h40;
	localparam logic [6:0]  TURN_BIT       = 7'h2e;
	localparam logic [6:0]  ACK_BIT        = 7'h2f;
	localparam logic [6:0]  DATA_BIT       = 7'h30;
	localparam logic [31:0] PREAMBLE       = 32'hffffffff;
	localparam logic [1:0]  ST_C22         = 2'h1;
	localparam logic [1:0]  ST_C45         = 2'h0;
	localparam logic [1:0]  OP_ADDR        = 2'h0;
	localparam logic [1:0]  OP_WRITE       = 2'h1;
	localparam logic [1:0]  OP_RD22        = 2'h2;
	localparam logic [1:0]  OP_RD45        = 2'h3;
	localparam logic [1:0]  TA_DRIVE       = 2'h2;
	localparam logic [4:0]  POLL_REG       = 5'h01;
	localparam logic [15:0] POLL_EXT_ADDR  = 16'h0001;
	localparam logic [1:0]  SRC_POLL       = 2'h2;
	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        go;
		logic        write;
		logic        ack;
		logic [2:0]  rsvd;
		logic [4:0]  reg_or_device_select;
		logic [4:0]  target_select;
		logic [15:0] data;
	} access_type;
	typedef struct packed {
		logic clk;
		logic data;
		logic oe_b;
	} pin_out_type;
endpackage

// [core/sync_two_flop.sv]
`timescale 1ns/100ps
module sync_two_flop #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_sync_b,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // sync_two_flop

// [core/mgmt_clock_gen.sv]
`timescale 1ns/100ps
module mgmt_clock_gen #(
	parameter int DIV_W = 16
) (
	input  wire logic             mclk,
	input  wire logic             rst_sync_b,
	input  wire logic [DIV_W-1:0] mgmt_clock_divider,
	output logic                  mgmt_clock,
	output logic                  rise_tick,
	output logic                  fall_tick
);
	logic [DIV_W-1:0] cnt_reg;
	logic [DIV_W-1:0] half;

	assign half = mgmt_clock_divider >> 1;

	// period is divider plus one, stopped at zero
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cnt_reg    <= '0;
			mgmt_clock <= 1'b0;
			rise_tick  <= 1'b0;
			fall_tick  <= 1'b0;
		end else if (mgmt_clock_divider == '0) begin
			cnt_reg    <= '0;
			mgmt_clock <= 1'b0;
			rise_tick  <= 1'b0;
			fall_tick  <= 1'b0;
		end else if (cnt_reg >= mgmt_clock_divider) begin
			cnt_reg    <= '0;
			mgmt_clock <= 1'b1;
			rise_tick  <= 1'b1;
			fall_tick  <= 1'b0;
		end else begin
			cnt_reg    <= cnt_reg + 1'b1;
			rise_tick  <= 1'b0;
			fall_tick  <= (cnt_reg == half);
			if (cnt_reg == half) begin
				mgmt_clock <= 1'b0;
			end
		end
	end
endmodule // mgmt_clock_gen

// [core/mgmt_serial_master.sv]
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
module mgmt_serial_master (
	input  wire logic                          mclk,
	input  wire logic                          rst_b,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [mgmt_pkg::ADDR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	output logic                               mgmt_clock_out,
	output logic                               mdio_data_out,
	output logic                               mdio_oe_b,
	input  wire logic                          mdio_data_in,
	output logic      [1:0]                    cmd_done_irq,
	output logic                               any_change_irq_mode
);
	import mgmt_pkg::*;

	typedef enum logic {ENG_IDLE, ENG_SHIFT} eng_state_type;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic          rst_meta_reg;
	logic          rst_sync_b;
	logic          din_sync;
	logic          gen_clk;
	logic          rise_tick;
	logic          fall_tick;
	logic [15:0]   mgmt_clock_divider;
	logic          test_en_reg;
	logic          poll_on_reg;
	logic [1:0]    cmd_done_raw;
	logic [1:0]    cmd_done_masked;
	logic [1:0]    en_reg;
	logic [2:0]    man_reg;
	logic          software_pin_control;
	logic [7:0]    poll_gap_count;
	logic [31:0]   poll_mask_reg;
	logic [31:0]   format_reg;
	logic [15:0]   ext_address_a;
	logic [15:0]   ext_address_b;
	access_type    slot_reg [2];
	eng_state_type state_reg;
	logic [1:0]    src_reg;
	logic          addr_phase_reg;
	logic          rd_phase_reg;
	logic [63:0]   frame_reg;
	logic [6:0]    bit_cnt_reg;
	logic [15:0]   rx_reg;
	logic          ack_seen_reg;
	logic [4:0]    poll_ptr_reg;
	logic [7:0]    gap_cnt_reg;
	logic          eng_data_reg;
	logic          eng_oe_b_reg;
	pin_out_type   pin_next;
	logic          wb_req;
	logic          wb_wr;
	logic [31:0]   wmask;
	logic [31:0]   wd;
	logic [31:0]   rd_next;
	logic          run_ok;
	logic          start;
	logic [1:0]    pick_src;
	logic [1:0]    fsrc;
	logic [4:0]    f_phy;
	logic [4:0]    f_reg;
	logic          f_write;
	logic [15:0]   f_ext;
	logic          f_c45;
	logic [1:0]    f_op;
	logic          frame_end;
	logic [1:0]    slot_done;
	logic [6:0]    smp_idx;

	// ------------------------------------------------------------
	// reset release and pin sampling
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_sync_b   <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_b   <= rst_meta_reg;
		end
	end

	sync_two_flop #(.W(1)) u_din_sync (
		.mclk       (mclk),
		.rst_sync_b (rst_sync_b),
		.async_in   (mdio_data_in),
		.sync_out   (din_sync)
	);

	mgmt_clock_gen #(.DIV_W(16)) u_clock_gen (
		.mclk               (mclk),
		.rst_sync_b         (rst_sync_b),
		.mgmt_clock_divider (mgmt_clock_divider),
		.mgmt_clock         (gen_clk),
		.rise_tick          (rise_tick),
		.fall_tick          (fall_tick)
	);

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr  = wb_req & wb_we_i;
	assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wd     = wb_dat_i & wmask;

	always_comb begin
		rd_next = 32'h0;
		case (wb_adr_i)
			OFF_CONTROL:  rd_next = {1'b0, poll_on_reg, 12'h0, test_en_reg, 1'b0,
				mgmt_clock_divider};
			OFF_RAW:      rd_next = {30'h0, cmd_done_raw};
			OFF_MASKED:   rd_next = {30'h0, cmd_done_masked};
			OFF_EN_SET:   rd_next = {30'h0, en_reg};
			OFF_EN_CLR:   rd_next = {30'h0, en_reg};
			OFF_MANUAL:   rd_next = {29'h0, man_reg[2:1], din_sync};
			OFF_MODE_GAP: rd_next = {software_pin_control, any_change_irq_mode, 22'h0,
				poll_gap_count};
			OFF_POLL_EN:  rd_next = poll_mask_reg;
			OFF_FORMAT:   rd_next = format_reg;
			OFF_EXT0:     rd_next = {16'h0, ext_address_a};
			OFF_EXT1:     rd_next = {16'h0, ext_address_b};
			OFF_ACCESS0:  rd_next = slot_reg[0];
			OFF_ACCESS1:  rd_next = slot_reg[1];
			default:      rd_next = 32'h0;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req) begin
				wb_dat_o <= rd_next;
			end
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mgmt_clock_divider   <= DIV_RESET;
			test_en_reg          <= 1'b0;
			poll_on_reg          <= 1'b0;
			man_reg              <= 3'h0;
			software_pin_control <= 1'b0;
			any_change_irq_mode  <= 1'b0;
			poll_gap_count       <= 8'h0;
			poll_mask_reg        <= POLL_MASK_RST;
			format_reg           <= 32'h0;
			ext_address_a        <= 16'h0;
			ext_address_b        <= 16'h0;
		end else if (wb_wr) begin
			case (wb_adr_i)
				OFF_CONTROL: begin
					mgmt_clock_divider <= (mgmt_clock_divider & ~wmask[15:0]) | wd[15:0];
					if (wmask[CTRL_TEST_BIT]) begin
						test_en_reg <= wd[CTRL_TEST_BIT];
					end
					if (wmask[CTRL_POLL_BIT]) begin
						poll_on_reg <= wd[CTRL_POLL_BIT];
					end
				end
				OFF_MANUAL: man_reg <= (man_reg & ~wmask[2:0]) | wd[2:0];
				OFF_MODE_GAP: begin
					if (wmask[SWPIN_BIT]) begin
						software_pin_control <= wd[SWPIN_BIT];
					end
					if (wmask[ANYCHG_BIT]) begin
						any_change_irq_mode <= wd[ANYCHG_BIT];
					end
					poll_gap_count <= (poll_gap_count & ~wmask[7:0]) | wd[7:0];
				end
				OFF_POLL_EN: poll_mask_reg <= (poll_mask_reg & ~wmask) | wd;
				OFF_FORMAT:  format_reg <= (format_reg & ~wmask) | wd;
				OFF_EXT0:    ext_address_a <= (ext_address_a & ~wmask[15:0]) | wd[15:0];
				OFF_EXT1:    ext_address_b <= (ext_address_b & ~wmask[15:0]) | wd[15:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// command-done flags, set wins over clear
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cmd_done_raw    <= 2'h0;
			cmd_done_masked <= 2'h0;
			en_reg          <= 2'h0;
			cmd_done_irq    <= 2'h0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (wb_wr && wb_adr_i == OFF_EN_SET && wd[k]) begin
					en_reg[k] <= 1'b1;
				end else if (wb_wr && wb_adr_i == OFF_EN_CLR && wd[k]) begin
					en_reg[k] <= 1'b0;
				end
				if (slot_done[k] ||
					(test_en_reg && wb_wr && wb_adr_i == OFF_RAW && wd[k]) ||
					(test_en_reg && wb_wr && wb_adr_i == OFF_MASKED && wd[k])) begin
					cmd_done_raw[k] <= 1'b1;
				end else if (wb_wr && (wb_adr_i == OFF_RAW || wb_adr_i == OFF_MASKED)
					&& wd[k]) begin
					cmd_done_raw[k] <= 1'b0;
				end
				if ((slot_done[k] && en_reg[k]) ||
					(test_en_reg && wb_wr && wb_adr_i == OFF_MASKED && wd[k])) begin
					cmd_done_masked[k] <= 1'b1;
				end else if ((wb_wr && (wb_adr_i == OFF_RAW || wb_adr_i == OFF_MASKED)
					&& wd[k]) || (wb_wr && wb_adr_i == OFF_EN_CLR && wd[k])) begin
					cmd_done_masked[k] <= 1'b0;
				end
			end
			cmd_done_irq <= cmd_done_masked;
		end
	end

	// ------------------------------------------------------------
	// frame source selection
	// ------------------------------------------------------------
	assign run_ok   = !software_pin_control && mgmt_clock_divider != 16'h0;
	assign pick_src = slot_reg[0].go ? 2'h0 : (slot_reg[1].go ? 2'h1 : SRC_POLL);
	assign start    = state_reg == ENG_IDLE && run_ok && (slot_reg[0].go || slot_reg[1].go
		|| (poll_on_reg && gap_cnt_reg == 8'h0 && poll_mask_reg[poll_ptr_reg]));
	assign fsrc     = (state_reg == ENG_IDLE) ? pick_src : src_reg;

	always_comb begin
		f_phy   = poll_ptr_reg;
		f_reg   = POLL_REG;
		f_write = 1'b0;
		f_ext   = POLL_EXT_ADDR;
		if (fsrc != SRC_POLL) begin
			f_phy   = slot_reg[fsrc[0]].target_select;
			f_reg   = slot_reg[fsrc[0]].reg_or_device_select;
			f_write = slot_reg[fsrc[0]].write;
			f_ext   = fsrc[0] ? ext_address_b : ext_address_a;
		end
		f_c45 = format_reg[f_phy];
		f_op  = f_write ? OP_WRITE : (f_c45 ? OP_RD45 : OP_RD22);
	end

	assign frame_end = state_reg == ENG_SHIFT && fall_tick && bit_cnt_reg == FRAME_BITS;
	assign slot_done = {frame_end && !addr_phase_reg && src_reg == 2'h1,
		frame_end && !addr_phase_reg && src_reg == 2'h0};
	assign smp_idx   = bit_cnt_reg - 7'h1;

	// ------------------------------------------------------------
	// serial engine
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_reg      <= ENG_IDLE;
			src_reg        <= 2'h0;
			addr_phase_reg <= 1'b0;
			rd_phase_reg   <= 1'b0;
			frame_reg      <= 64'h0;
			bit_cnt_reg    <= 7'h0;
			rx_reg         <= 16'h0;
			ack_seen_reg   <= 1'b0;
			eng_data_reg   <= 1'b1;
			eng_oe_b_reg   <= 1'b1;
		end else begin
			case (state_reg)
				ENG_IDLE: begin
					eng_oe_b_reg <= 1'b1;
					if (start) begin
						state_reg   <= ENG_SHIFT;
						src_reg     <= pick_src;
						bit_cnt_reg <= 7'h0;
						if (f_c45) begin
							addr_phase_reg <= 1'b1;
							rd_phase_reg   <= 1'b0;
							frame_reg      <= {PREAMBLE, ST_C45, OP_ADDR, f_phy, f_reg,
								TA_DRIVE, f_ext};
						end else begin
							addr_phase_reg <= 1'b0;
							rd_phase_reg   <= !f_write;
							frame_reg      <= {PREAMBLE, ST_C22, f_op, f_phy, f_reg,
								TA_DRIVE, slot_reg[pick_src[0]].data};
						end
					end
				end
				ENG_SHIFT: begin
					if (frame_end) begin
						bit_cnt_reg <= 7'h0;
						if (addr_phase_reg) begin
							addr_phase_reg <= 1'b0;
							rd_phase_reg   <= !f_write;
							frame_reg      <= {PREAMBLE, ST_C45, f_op, f_phy, f_reg,
								TA_DRIVE, slot_reg[src_reg[0]].data};
						end else begin
							state_reg    <= ENG_IDLE;
							eng_oe_b_reg <= 1'b1;
						end
					end else if (fall_tick) begin
						eng_data_reg <= frame_reg[63];
						eng_oe_b_reg <= rd_phase_reg && bit_cnt_reg >= TURN_BIT;
						frame_reg    <= {frame_reg[62:0], 1'b0};
						bit_cnt_reg  <= bit_cnt_reg + 7'h1;
					end
					if (rise_tick && rd_phase_reg && bit_cnt_reg != 7'h0) begin
						if (smp_idx == ACK_BIT) begin
							ack_seen_reg <= !din_sync;
						end
						if (smp_idx >= DATA_BIT) begin
							rx_reg <= {rx_reg[14:0], din_sync};
						end
					end
				end
				default: state_reg <= ENG_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// poll walk and inter-poll gap
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			poll_ptr_reg <= 5'h0;
			gap_cnt_reg  <= 8'h0;
		end else begin
			if (frame_end && !addr_phase_reg && src_reg == SRC_POLL) begin
				poll_ptr_reg <= poll_ptr_reg + 5'h1;
				gap_cnt_reg  <= poll_gap_count;
			end else if (rise_tick && gap_cnt_reg != 8'h0) begin
				gap_cnt_reg <= gap_cnt_reg - 8'h1;
			end else if (state_reg == ENG_IDLE && poll_on_reg
				&& !poll_mask_reg[poll_ptr_reg]) begin
				poll_ptr_reg <= poll_ptr_reg + 5'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// user access slots
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			slot_reg[0] <= '0;
			slot_reg[1] <= '0;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (slot_done[k]) begin
					slot_reg[k].go <= 1'b0;
					if (slot_reg[k].write == 1'b0) begin
						slot_reg[k].data <= rx_reg;
						slot_reg[k].ack  <= ack_seen_reg;
					end
				end else if (wb_wr && !slot_reg[k].go && wb_adr_i ==
					(k == 0 ? OFF_ACCESS0 : OFF_ACCESS1)) begin
					slot_reg[k]      <= (slot_reg[k] & ~wmask) | wd;
					slot_reg[k].rsvd <= 3'h0;
					slot_reg[k].go   <= wd[31] && mgmt_clock_divider != 16'h0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	always_comb begin
		pin_next.clk  = gen_clk;
		pin_next.data = eng_data_reg;
		pin_next.oe_b = eng_oe_b_reg;
		if (software_pin_control) begin
			pin_next.clk  = man_reg[MAN_CLK_BIT];
			pin_next.data = man_reg[MAN_PIN_BIT];
			pin_next.oe_b = !man_reg[MAN_OE_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mgmt_clock_out <= 1'b0;
			mdio_data_out  <= 1'b1;
			mdio_oe_b      <= 1'b1;
		end else begin
			mgmt_clock_out <= pin_next.clk;
			mdio_data_out  <= pin_next.data;
			mdio_oe_b      <= pin_next.oe_b;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_raw_set:
	assert property (@(posedge mclk) disable iff (!rst_sync_b)
		slot_done[0] |=> cmd_done_raw[0]) else $error("raw bit not set on done");
	chk_raw_clear:
	assert property (@(posedge mclk) disable iff (!rst_sync_b)
		(wb_wr && wb_adr_i == OFF_RAW && wd[1] && !test_en_reg && !slot_done[1])
		|=> !cmd_done_raw[1]) else $error("raw bit not cleared");
	chk_test_force:
	assert property (@(posedge mclk) disable iff (!rst_sync_b)
		(wb_wr && wb_adr_i == OFF_RAW && wd[0] && test_en_reg) |=> cmd_done_raw[0])
		else $error("raw bit not forced");
	chk_masked_gate:
	assert property (@(posedge mclk) disable iff (!rst_sync_b)
		!$past(test_en_reg) && !test_en_reg |-> (cmd_done_masked & ~cmd_done_raw) == 2'h0)
		else $error("masked bit without raw");
	chk_enable_set:
	assert property (@(posedge mclk) disable iff (!rst_sync_b)
		(wb_wr && wb_adr_i == OFF_EN_SET && wd[1]) |=> en_reg[1])
		else $error("enable not set");
	chk_enable_clear:
	assert property (@(posedge mclk) disable iff (!rst_sync_b)
		(wb_wr && wb_adr_i == OFF_EN_CLR && wd[0]) |=> !en_reg[0] && !cmd_done_masked[0])
		else $error("enable not cleared");
	chk_manual_clock:
	assert property (@(posedge mclk) disable iff (!rst_sync_b)
		software_pin_control |=> mgmt_clock_out == $past(man_reg[MAN_CLK_BIT]))
		else $error("manual clock not driven");
	chk_manual_oe:
	assert property (@(posedge mclk) disable iff (!rst_sync_b)
		software_pin_control |=> mdio_oe_b == !$past(man_reg[MAN_OE_BIT]))
		else $error("manual enable not inverted");
	chk_go_clear:
	assert property (@(posedge mclk) disable iff (!rst_sync_b)
		slot_done[1] |=> !slot_reg[1].go)
		else $error("launch bit not cleared");
	chk_irq_follow:
	assert property (@(posedge mclk) disable iff (!rst_sync_b)
		cmd_done_masked[0] ##1 cmd_done_masked[0] |-> cmd_done_irq[0])
		else $error("interrupt output lags");
endmodule // mgmt_serial_master

// [verification/phy_reply_model.sv]
`timescale 1ns/100ps
module phy_reply_model #(
	parameter logic [15:0] REPLY = 16'ha5c3
) (
	input  wire logic mgmt_clock_out,
	input  wire logic mdio_data_out,
	input  wire logic mdio_oe_b,
	output logic      mdio_data_in
);
	logic [4:0] k_reg = 5'h00;
	// counts released bit times
	always @(negedge mgmt_clock_out) begin
		k_reg <= mdio_oe_b ? k_reg + 5'h01 : 5'h00;
	end
	// ack low, then reply msb first, pull-up otherwise
	assign mdio_data_in = !mdio_oe_b ? mdio_data_out :
		(k_reg == 5'h01) ? 1'b0 :
		(k_reg >= 5'h02 && k_reg <= 5'h11) ? REPLY[5'h11 - k_reg] : 1'b1;
endmodule // phy_reply_model

// [verification/tb.sv]
`timescale 1ns/100ps
module tb;
	import mgmt_pkg::*;
	localparam logic [15:0] REPLY = 16'ha5c3;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] q;
	logic [31:0] rdat;
	logic        ack, mclk_o, d_out, oe_b, d_in, mode;
	logic [1:0]  irq;
	int          n_fail = 0;
	int          compares = 0;
`define CK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
	mgmt_serial_master u_mgmt_serial_master (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .mgmt_clock_out(mclk_o), .mdio_data_out(d_out),
		.mdio_oe_b(oe_b), .mdio_data_in(d_in), .cmd_done_irq(irq), .any_change_irq_mode(mode));
	phy_reply_model #(.REPLY(REPLY)) u_phy_reply_model (.mgmt_clock_out(mclk_o),
		.mdio_data_out(d_out), .mdio_oe_b(oe_b), .mdio_data_in(d_in));
	initial begin
		forever #25 mclk = ~mclk;
	end
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge mclk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic t_reset;
		wb(1'b0, OFF_POLL_EN, 32'h0);
		`CK(q, POLL_MASK_RST)
		wb(1'b0, OFF_RAW, 32'h0);
		`CK(q, 32'h0)
		wb(1'b1, OFF_FORMAT, 32'h20);
		wb(1'b0, OFF_FORMAT, 32'h0);
		`CK(q, 32'h20)
		$display("reset test done");
	endtask
	task automatic t_manual;
		wb(1'b1, OFF_MODE_GAP, 32'hc000_0000);
		`CK(mode, 1'b1)
		wb(1'b1, OFF_MANUAL, 32'h7);
		`CK({mclk_o, oe_b, d_out}, 3'b101)
		// input passes two sync flops
		repeat (3) @(posedge mclk);
		wb(1'b0, OFF_MANUAL, 32'h0);
		`CK(q[0], 1'b1)
		wb(1'b1, OFF_MANUAL, 32'h2);
		repeat (3) @(posedge mclk);
		wb(1'b0, OFF_MANUAL, 32'h0);
		`CK(q[0], 1'b0)
		`CK({mclk_o, oe_b, d_out}, 3'b000)
		wb(1'b1, OFF_MODE_GAP, 32'h0);
		`CK(mode, 1'b0)
		$display("manual test done");
	endtask
	task automatic t_user;
		int i;
		// divider 7 keeps sync delay inside half a bit
		wb(1'b1, OFF_CONTROL, 32'h7);
		wb(1'b1, OFF_EN_SET, 32'h1);
		wb(1'b1, OFF_ACCESS0, 32'h8045_0000);
		wb(1'b1, OFF_ACCESS0, 32'h8046_0000);
		q = 32'h8000_0000;
		for (i = 0; i < 1000 && q[31]; i++)
			wb(1'b0, OFF_ACCESS0, 32'h0);
		`CK(q, {16'h2045, REPLY})
		wb(1'b0, OFF_MASKED, 32'h0);
		`CK(q, 32'h1)
		`CK(irq, 2'b01)
		wb(1'b1, OFF_EN_CLR, 32'h1);
		wb(1'b0, OFF_MASKED, 32'h0);
		`CK(q, 32'h0)
		wb(1'b1, OFF_ACCESS1, 32'hc021_1234);
		q = 32'h8000_0000;
		for (i = 0; i < 1000 && q[31]; i++)
			wb(1'b0, OFF_ACCESS1, 32'h0);
		`CK(q, 32'h4021_1234)
		wb(1'b0, OFF_RAW, 32'h0);
		`CK(q, 32'h3)
		wb(1'b1, OFF_RAW, 32'h2);
		wb(1'b0, OFF_RAW, 32'h0);
		`CK(q, 32'h1)
		wb(1'b1, OFF_RAW, 32'h1);
		wb(1'b0, OFF_RAW, 32'h0);
		`CK(q, 32'h0)
		$display("user access test done");
	endtask
	task automatic t_force;
		wb(1'b1, OFF_CONTROL, 32'h0002_0007);
		wb(1'b1, OFF_EN_SET, 32'h2);
		wb(1'b1, OFF_RAW, 32'h2);
		wb(1'b0, OFF_RAW, 32'h0);
		`CK(q, 32'h2)
		wb(1'b0, OFF_MASKED, 32'h0);
		`CK(q, 32'h0)
		wb(1'b1, OFF_MASKED, 32'h2);
		wb(1'b0, OFF_MASKED, 32'h0);
		`CK(q, 32'h2)
		`CK(irq, 2'b10)
		wb(1'b1, OFF_MASKED, 32'h1);
		wb(1'b0, OFF_MASKED, 32'h0);
		`CK(q, 32'h3)
		wb(1'b1, OFF_CONTROL, 32'h7);
		wb(1'b1, OFF_MASKED, 32'h1);
		wb(1'b0, OFF_MASKED, 32'h0);
		`CK(q[0], 1'b0)
		$display("force test done");
	endtask
	task automatic close_out;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#2000000;
		n_fail++;
		close_out;
	end
	// poll mask never written, bit 31 stays set
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset;
		t_manual;
		t_user;
		t_force;
		close_out;
	end
endmodule // tb
